/* File: rtl/pdc_channels.sv */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pdc_regs.svh"

module pdc_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

module pdc_channels (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral handshakes
  input wire logic [`PDC_NCH-1:0] periph_req,
  input wire logic [`PDC_NCH-1:0] periph_event,
  input wire logic [`PDC_NCH-1:0][31:0] periph_rx_data,
  output logic [`PDC_NCH-1:0] periph_ack,
  // items toward peripherals
  output logic periph_tx_valid,
  input wire logic periph_tx_ready,
  output pdc_pkg::pdc_item_type periph_tx_item,
  // system memory
  output logic mem_valid,
  output pdc_pkg::pdc_mem_req_type mem_req,
  input wire logic mem_done,
  input wire logic mem_error,
  input wire logic [31:0] mem_rdata
);
  localparam int NCH = `PDC_NCH;
  localparam int CW = `PDC_CH_W;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nv, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nv[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] step(input pdc_pkg::pdc_size_type s);
    unique case (s)
      pdc_pkg::PDC_SZ_BYTE: return 32'h0000_0001;
      pdc_pkg::PDC_SZ_HALF: return 32'h0000_0002;
      pdc_pkg::PDC_SZ_WORD: return 32'h0000_0004;
      pdc_pkg::PDC_SZ_RSVD: return 32'h0000_0004;
    endcase
  endfunction

  // upper bits zero for narrow items
  function automatic logic [31:0] size_mask(input pdc_pkg::pdc_size_type s,
      input logic [31:0] d);
    unique case (s)
      pdc_pkg::PDC_SZ_BYTE: return {24'h00_0000, d[7:0]};
      pdc_pkg::PDC_SZ_HALF: return {16'h0000, d[15:0]};
      pdc_pkg::PDC_SZ_WORD: return d;
      pdc_pkg::PDC_SZ_RSVD: return d;
    endcase
  endfunction

  function automatic logic [CW-1:0] pick_low(input logic [NCH-1:0] v);
    logic [CW-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = CW'(i);
      end
    end
    return r;
  endfunction

  // channel state
  logic [31:0] ptr_q [NCH];
  logic [7:0] sel_q [NCH];
  logic [15:0] cnt_q [NCH];
  logic [31:0] arel_q [NCH];
  logic [15:0] crel_q [NCH];
  logic [3:0] setup_q [NCH];
  logic [NCH-1:0] en_q;
  logic [NCH-1:0] fault_q;
  logic [NCH-1:0] evp_q;
  logic [2:0] armed_q [NCH];

  // bus slave
  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic win_hit;
  logic [CW-1:0] wr_ch;
  logic [5:0] wr_off;
  logic [31:0] rd_val;

  // engine
  pdc_pkg::pdc_state_type state_q;
  logic [CW-1:0] cur_q;
  pdc_pkg::pdc_mem_req_type req_q;
  logic [NCH-1:0] ack_out_q;
  logic [NCH-1:0] elig;
  logic any_elig;
  logic [CW-1:0] pick;
  logic start;
  logic done_ok;
  logic done_err;
  logic fifo_in_ready;
  pdc_pkg::pdc_item_type push_item;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign wr_go = avs_write && ack_q;
  assign win_hit = (avs_address[11:`PDC_WIN_SHIFT] < 6'(NCH));
  assign wr_ch = avs_address[`PDC_WIN_SHIFT+CW-1:`PDC_WIN_SHIFT];
  assign wr_off = {avs_address[5:2], 2'b00};

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (avs_address == `PDC_OFF_VERSION) begin
      rd_val = `PDC_VERSION_VALUE;
    end else if (win_hit) begin
      unique case (wr_off)
        `PDC_OFF_PTR: rd_val = ptr_q[wr_ch];
        `PDC_OFF_SEL: rd_val = {24'h00_0000, sel_q[wr_ch]};
        `PDC_OFF_CNT: rd_val = {16'h0000, cnt_q[wr_ch]};
        `PDC_OFF_AREL: rd_val = arel_q[wr_ch];
        `PDC_OFF_CREL: rd_val = {16'h0000, crel_q[wr_ch]};
        `PDC_OFF_SETUP: rd_val = {28'h000_0000, setup_q[wr_ch]};
        `PDC_OFF_STATE: rd_val = {31'h0000_0000, en_q[wr_ch]};
        `PDC_OFF_ARMED: rd_val = {29'h0000_0000, armed_q[wr_ch]};
        `PDC_OFF_FLAGS: begin
          rd_val[`PDC_IRQ_RCZ] = (crel_q[wr_ch] == 16'h0000);
          rd_val[`PDC_IRQ_TRC] = (crel_q[wr_ch] == 16'h0000)
              && (cnt_q[wr_ch] == 16'h0000);
          rd_val[`PDC_IRQ_FAULT_FLAG] = fault_q[wr_ch];
        end
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_val;
    end
  end

  // eligibility and arbitration
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      elig[c] = en_q[c] && !fault_q[c] && (cnt_q[c] != 16'h0000)
          && periph_req[c]
          && (!setup_q[c][`PDC_SETUP_EVENT_GATED_START] || evp_q[c])
          && (!sel_q[c][`PDC_SEL_DIR] || fifo_in_ready);
    end
  end

  assign any_elig = |elig;
  assign pick = pick_low(elig);
  assign start = (state_q == pdc_pkg::PDC_ST_IDLE) && any_elig;
  assign done_ok = (state_q == pdc_pkg::PDC_ST_BUSY) && mem_done && !mem_error;
  assign done_err = (state_q == pdc_pkg::PDC_ST_BUSY) && mem_done && mem_error;
  assign mem_valid = (state_q == pdc_pkg::PDC_ST_BUSY);
  assign mem_req = req_q;
  assign periph_ack = ack_out_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= pdc_pkg::PDC_ST_IDLE;
    end else begin
      unique case (state_q)
        pdc_pkg::PDC_ST_IDLE: begin
          if (any_elig) begin
            state_q <= pdc_pkg::PDC_ST_BUSY;
          end
        end
        pdc_pkg::PDC_ST_BUSY: begin
          if (mem_done) begin
            state_q <= pdc_pkg::PDC_ST_IDLE;
          end
        end
      endcase
    end
  end

  // latch one item's access
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_q <= '0;
      req_q <= '0;
    end else if (start) begin
      cur_q <= pick;
      req_q.write <= !sel_q[pick][`PDC_SEL_DIR];
      req_q.size <= pdc_pkg::pdc_size_type'(setup_q[pick][1:0]);
      req_q.addr <= ptr_q[pick];
      req_q.wdata <= size_mask(pdc_pkg::pdc_size_type'(setup_q[pick][1:0]),
          periph_rx_data[pick]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_out_q <= '0;
    end else begin
      ack_out_q <= '0;
      if (done_ok) begin
        ack_out_q[cur_q] <= 1'b1;
      end
    end
  end

  // pointer, counter and reload bookkeeping
  always_ff @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (reset) begin
        ptr_q[c] <= `PDC_RST_PTR;
        cnt_q[c] <= `PDC_RST_CNT;
        arel_q[c] <= `PDC_RST_PTR;
        crel_q[c] <= `PDC_RST_CNT;
      end else begin
        if (done_ok && cur_q == CW'(c)) begin
          if (cnt_q[c] == 16'h0001 && crel_q[c] != 16'h0000) begin
            cnt_q[c] <= crel_q[c];
            ptr_q[c] <= arel_q[c];
            if (!setup_q[c][`PDC_SETUP_RING]) begin
              crel_q[c] <= 16'h0000;
              arel_q[c] <= 32'h0000_0000;
            end
          end else begin
            cnt_q[c] <= cnt_q[c] - 16'h0001;
            ptr_q[c] <= ptr_q[c] + step(req_q.size);
          end
        end
        if (wr_go && win_hit && wr_ch == CW'(c)) begin
          unique case (wr_off)
            `PDC_OFF_PTR: ptr_q[c] <= merge(ptr_q[c], avs_writedata,
                avs_byteenable);
            `PDC_OFF_CNT: cnt_q[c] <= 16'(merge({16'h0000, cnt_q[c]},
                avs_writedata, avs_byteenable));
            `PDC_OFF_AREL: arel_q[c] <= merge(arel_q[c], avs_writedata,
                avs_byteenable);
            `PDC_OFF_CREL: begin
              crel_q[c] <= 16'(merge({16'h0000, crel_q[c]}, avs_writedata,
                  avs_byteenable));
              if (cnt_q[c] == 16'h0000) begin
                cnt_q[c] <= 16'(merge({16'h0000, crel_q[c]}, avs_writedata,
                    avs_byteenable));
                ptr_q[c] <= arel_q[c];
                if (!setup_q[c][`PDC_SETUP_RING]) begin
                  crel_q[c] <= 16'h0000;
                  arel_q[c] <= 32'h0000_0000;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // setup and select registers
  always_ff @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (reset) begin
        sel_q[c] <= `PDC_RST_SEL;
        setup_q[c] <= `PDC_RST_SETUP;
      end else if (wr_go && win_hit && wr_ch == CW'(c)) begin
        if (wr_off == `PDC_OFF_SEL && avs_byteenable[0]) begin
          sel_q[c] <= avs_writedata[7:0];
        end
        if (wr_off == `PDC_OFF_SETUP && avs_byteenable[0]) begin
          setup_q[c] <= avs_writedata[3:0];
        end
      end
    end
  end

  // enable, fault, event and arm flags
  always_ff @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (reset) begin
        en_q[c] <= 1'b0;
        fault_q[c] <= 1'b0;
        evp_q[c] <= 1'b0;
        armed_q[c] <= `PDC_RST_ARMED;
      end else begin
        if (wr_go && win_hit && wr_ch == CW'(c)) begin
          if (wr_off == `PDC_OFF_CMD && avs_byteenable[0]) begin
            if (avs_writedata[`PDC_CMD_GO]) begin
              en_q[c] <= 1'b1;
            end
            if (avs_writedata[`PDC_CMD_STOP]) begin
              en_q[c] <= 1'b0;
            end
          end
          if (wr_off == `PDC_OFF_CMD && avs_byteenable[1]
              && avs_writedata[`PDC_CMD_CLR]) begin
            fault_q[c] <= 1'b0;
          end
          if (wr_off == `PDC_OFF_ARM && avs_byteenable[0]) begin
            armed_q[c] <= armed_q[c] | avs_writedata[2:0];
          end
          if (wr_off == `PDC_OFF_DISARM && avs_byteenable[0]) begin
            armed_q[c] <= armed_q[c] & ~avs_writedata[2:0];
          end
        end
        if (start && pick == CW'(c)
            && setup_q[c][`PDC_SETUP_EVENT_GATED_START]) begin
          evp_q[c] <= 1'b0;
        end
        if (periph_event[c]) begin
          evp_q[c] <= 1'b1;
        end
        if (done_err && cur_q == CW'(c)) begin
          fault_q[c] <= 1'b1;
        end
      end
    end
  end

  // read items queue toward peripherals
  always_comb begin
    push_item.chan = cur_q;
    push_item.sel = sel_q[cur_q];
    push_item.data = size_mask(req_q.size, mem_rdata);
  end

  pdc_fifo #(
    .WIDTH($bits(pdc_pkg::pdc_item_type)),
    .DEPTH(16)
  ) u_tx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(done_ok && !req_q.write),
    .in_ready(fifo_in_ready),
    .in_data(push_item),
    .out_valid(periph_tx_valid),
    .out_ready(periph_tx_ready),
    .out_data(periph_tx_item)
  );
endmodule

/* File: rtl/pdc_regs.svh */
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// channel count and window layout
`define PDC_NCH 4
`define PDC_CH_W 2
`define PDC_WIN_SHIFT 6

// offsets inside a channel window, then the full version register address
`define PDC_OFF_PTR 6'h00
`define PDC_OFF_SEL 6'h04
`define PDC_OFF_CNT 6'h08
`define PDC_OFF_AREL 6'h0C
`define PDC_OFF_CREL 6'h10
`define PDC_OFF_CMD 6'h14
`define PDC_OFF_SETUP 6'h18
`define PDC_OFF_STATE 6'h1C
`define PDC_OFF_ARM 6'h20
`define PDC_OFF_DISARM 6'h24
`define PDC_OFF_ARMED 6'h28
`define PDC_OFF_FLAGS 6'h2C
`define PDC_OFF_VERSION 12'h834

// field positions
`define PDC_CMD_GO 0
`define PDC_CMD_STOP 1
`define PDC_CMD_CLR 8
`define PDC_SETUP_EVENT_GATED_START 2
`define PDC_SETUP_RING 3
`define PDC_STATE_EN 0
`define PDC_IRQ_RCZ 0
`define PDC_IRQ_TRC 1
`define PDC_IRQ_FAULT_FLAG 2
`define PDC_SEL_DIR 7

// reset values, then the version value
`define PDC_RST_PTR 32'h0000_0000
`define PDC_RST_SEL 8'h00
`define PDC_RST_CNT 16'h0000
`define PDC_RST_SETUP 4'h0
`define PDC_RST_ARMED 3'h0
`define PDC_VERSION_VALUE 32'h0000_0100

`endif

/* File: rtl/pdc_pkg.sv */
package pdc_pkg;
  `include "pdc_regs.svh"

  typedef enum logic [1:0] {
    PDC_SZ_BYTE = 2'b00,
    PDC_SZ_HALF = 2'b01,
    PDC_SZ_WORD = 2'b10,
    PDC_SZ_RSVD = 2'b11
  } pdc_size_type;

  typedef enum logic {
    PDC_ST_IDLE = 1'b0,
    PDC_ST_BUSY = 1'b1
  } pdc_state_type;

  // item going out to a peripheral
  typedef struct packed {
    logic [`PDC_CH_W-1:0] chan;
    logic [7:0] sel;
    logic [31:0] data;
  } pdc_item_type;

  // memory access of one item
  typedef struct packed {
    logic write;
    pdc_size_type size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdc_mem_req_type;
endpackage

/* File: dv/pdc_channels_sva.sv */
`timescale 1ns/1ps
`include "pdc_regs.svh"
module pdc_channels_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // engine
  input wire logic [`PDC_NCH-1:0] periph_ack,
  input wire logic periph_tx_valid,
  input wire logic mem_valid,
  input wire pdc_pkg::pdc_mem_req_type mem_req,
  input wire logic mem_done,
  input wire logic mem_error
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_done;
    mem_valid && mem_done;
  endsequence
  sequence s_ok;
    s_done ##0 !mem_error;
  endsequence
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_hold;
    mem_valid && !mem_done |=> mem_valid && $stable(mem_req);
  endproperty
  a_hold: assert property (p_hold) else $error("access moved");
  property p_ack;
    s_ok |=> $onehot(periph_ack);
  endproperty
  a_ack: assert property (p_ack) else $error("no item ack");
  property p_err;
    s_done ##0 mem_error |=> periph_ack == '0;
  endproperty
  a_err: assert property (p_err) else $error("ack on failed access");
  property p_gap;
    s_done |=> !mem_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle");
  property p_cause;
    (|periph_ack) |-> $past(mem_valid) && $past(mem_done)
      && !$past(mem_error) ##1 periph_ack == '0;
  endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_txv;
    $rose(periph_tx_valid) |-> (|periph_ack);
  endproperty
  a_txv: assert property (p_txv) else $error("item without ack");
  property p_ver;
    avs_read && avs_address == `PDC_OFF_VERSION && !avs_waitrequest
      |-> avs_readdata == `PDC_VERSION_VALUE;
  endproperty
  a_ver: assert property (p_ver) else $error("version wrong");
  property p_wo;
    avs_read && avs_address[5:0] == `PDC_OFF_CMD && !avs_waitrequest
      |-> avs_readdata == 32'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("command reads nonzero");
endmodule

bind pdc_channels pdc_channels_sva i_sva (
  .clk(clk),
  .reset(reset),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .periph_ack(periph_ack),
  .periph_tx_valid(periph_tx_valid),
  .mem_valid(mem_valid),
  .mem_req(mem_req),
  .mem_done(mem_done),
  .mem_error(mem_error)
);

/* File: dv/pdc_mem_model.sv */
`timescale 1ns/1ps
module pdc_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // memory side
  input wire logic mem_valid,
  input wire pdc_pkg::pdc_mem_req_type mem_req,
  output logic mem_done,
  output logic mem_error,
  output logic [31:0] mem_rdata,
  // pacing
  input wire logic slow,
  input wire logic stall,
  output logic tx_ready
);
  logic [1:0] wait_q;
  logic [31:0] pat;
  always_ff @(posedge clk) begin
    if (reset || !mem_valid || mem_done) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // slow answers after three cycles
  assign mem_done = mem_valid && (!slow || wait_q == 2'h3);
  // region with address bits 31:28 equal to 0xE is unmapped
  assign mem_error = mem_done && mem_req.addr[31:28] == 4'hE;
  assign pat = mem_req.addr ^ 32'h5A5A_A5A5;
  // inverse pattern outside an answer
  assign mem_rdata = mem_done ? pat : ~pat;
  assign tx_ready = !stall;
endmodule

/* File: dv/pdc_channels_test.sv */
`timescale 1ns/1ps
`include "pdc_regs.svh"
module pdc_channels_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] addr = 12'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic [3:0] req = 4'h0;
  logic [3:0] evt = 4'h0;
  logic [3:0] ack;
  logic [3:0] seen_ack;
  logic [3:0][31:0] rx = {32'h3333_3333, 32'h2222_2222,
    32'h1111_1111, 32'h89AB_CDEF};
  logic tx_valid;
  logic tx_ready;
  logic mem_valid;
  logic mem_done;
  logic mem_error;
  logic [31:0] mem_rdata;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] mask [3] = '{32'hFF, 32'hFFFF, 32'hFFFF_FFFF};
  logic [11:0] offs [12] = '{12'h000, 12'h004, 12'h008, 12'h00C,
    12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h028, 12'h030,
    12'h100};
  pdc_pkg::pdc_item_type item;
  pdc_pkg::pdc_mem_req_type mreq;
  pdc_pkg::pdc_mem_req_type last_req;
  int fail_count = 0;
  int n_checks = 0;
  int k;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (mem_valid) begin
      last_req <= mreq;
    end
  end
  pdc_channels i_dut (.clk(clk), .reset(reset), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .periph_req(req), .periph_event(evt),
    .periph_rx_data(rx), .periph_ack(ack), .periph_tx_valid(tx_valid),
    .periph_tx_ready(tx_ready), .periph_tx_item(item),
    .mem_valid(mem_valid), .mem_req(mreq), .mem_done(mem_done),
    .mem_error(mem_error), .mem_rdata(mem_rdata));
  pdc_mem_model i_mem (.clk(clk), .reset(reset), .mem_valid(mem_valid),
    .mem_req(mreq), .mem_done(mem_done), .mem_error(mem_error),
    .mem_rdata(mem_rdata), .slow(slow), .stall(stall),
    .tx_ready(tx_ready));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    addr <= a;
    wdata <= d;
    rd_en <= ~w;
    wr_en <= w;
    do begin
      @(posedge clk);
      i++;
    end while (wait_req !== 1'b0 && i < 50);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (wait_req !== 1'b0) begin
      fail_count++;
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, $sformatf("register %h", a));
  endtask
  task automatic acks(input int n);
    for (int i = 0; i < 400 && n > 0; i++) begin
      @(posedge clk);
      if (ack !== 4'h0) begin
        seen_ack = ack;
        n--;
      end
    end
    if (n > 0) begin
      fail_count++;
      conclude();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(12'h834, `PDC_VERSION_VALUE);
    wr(12'h030, 32'hFFFF_FFFF);
    rd(12'h030, 32'h0);
    wr(12'h044, 32'hFFFF_FFFF);
    rd(12'h044, 32'hFF);
    wr(12'h058, 32'hFFFF_FFFF);
    rd(12'h058, 32'hF);
    wr(12'h040, 32'h1234_5678);
    rd(12'h040, 32'h1234_5678);
    rd(12'h000, 32'h0);
    be <= 4'h1;
    wr(12'h040, 32'hFFFF_FFFF);
    be <= 4'hF;
    rd(12'h040, 32'h1234_56FF);
    wr(12'h044, 32'h0);
    wr(12'h058, 32'h0);
    // one-only go and stop
    wr(12'h014, 32'h1);
    rd(12'h01C, 32'h1);
    wr(12'h014, 32'h0);
    rd(12'h01C, 32'h1);
    wr(12'h014, 32'h3);
    rd(12'h01C, 32'h0);
    wr(12'h014, 32'h1);
    // sizes, peripheral to memory
    for (k = 0; k < 3; k++) begin
      wr(12'h018, 32'(k));
      wr(12'h000, 32'h100);
      wr(12'h008, 32'h2);
      req <= 4'h1;
      acks(2);
      req <= 4'h0;
      rd(12'h000, 32'h100 + (32'h2 << k));
      rd(12'h008, 32'h0);
      chk(last_req.wdata, 32'h89AB_CDEF & mask[k], "mem wdata");
      chk(32'(last_req.size), 32'(k), "mem size");
      chk(last_req.addr, 32'h100 + (32'h1 << k), "mem addr");
    end
    // reload without ring
    wr(12'h000, 32'h100);
    wr(12'h008, 32'h1);
    wr(12'h00C, 32'h200);
    wr(12'h010, 32'h2);
    req <= 4'h1;
    acks(3);
    repeat (20) @(posedge clk);
    rd(12'h000, 32'h208);
    rd(12'h010, 32'h0);
    rd(12'h008, 32'h0);
    req <= 4'h0;
    // ring keeps reloads
    wr(12'h018, 32'hA);
    wr(12'h000, 32'h300);
    wr(12'h008, 32'h1);
    wr(12'h00C, 32'h300);
    wr(12'h010, 32'h1);
    req <= 4'h1;
    acks(3);
    req <= 4'h0;
    repeat (5) @(posedge clk);
    rd(12'h010, 32'h1);
    rd(12'h00C, 32'h300);
    wr(12'h010, 32'h0);
    wr(12'h008, 32'h0);
    wr(12'h018, 32'h2);
    // fault and restart
    wr(12'h000, 32'hE000_0000);
    wr(12'h008, 32'h2);
    req <= 4'h1;
    repeat (10) @(posedge clk);
    rd(12'h008, 32'h2);
    rd(12'h02C, 32'h5);
    wr(12'h014, 32'h0);
    rd(12'h02C, 32'h5);
    wr(12'h000, 32'h400);
    wr(12'h014, 32'h100);
    acks(2);
    req <= 4'h0;
    rd(12'h02C, 32'h3);
    // priority
    wr(12'h054, 32'h1);
    wr(12'h048, 32'h1);
    wr(12'h008, 32'h1);
    req <= 4'h3;
    acks(1);
    chk(32'(seen_ack), 32'h1, "first ack");
    acks(1);
    chk(32'(seen_ack), 32'h2, "second ack");
    chk(last_req.wdata, 32'h11, "ch1 wdata");
    req <= 4'h0;
    // event gating
    wr(12'h094, 32'h1);
    wr(12'h098, 32'h4);
    wr(12'h088, 32'h1);
    req <= 4'h4;
    repeat (20) @(posedge clk);
    rd(12'h088, 32'h1);
    evt <= 4'h4;
    @(posedge clk);
    evt <= 4'h0;
    acks(1);
    rd(12'h088, 32'h0);
    req <= 4'h0;
    // memory to peripheral through full buffer
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h600);
    stall <= 1'b1;
    slow <= 1'b1;
    wr(12'h008, 32'd20);
    req <= 4'h1;
    repeat (200) @(posedge clk);
    rd(12'h008, 32'h4);
    chk(item.data, 32'h600 ^ 32'h5A5A_A5A5, "item data");
    chk(32'(item.sel), 32'h80, "item sel");
    chk(32'(item.chan), 32'h0, "item chan");
    chk(32'(last_req.write), 32'h0, "mem write");
    stall <= 1'b0;
    acks(4);
    for (k = 0; k < 50 && tx_valid !== 1'b0; k++) @(posedge clk);
    chk(32'(tx_valid), 32'h0, "tx valid");
    rd(12'h000, 32'h650);
    // reload write while count is zero
    wr(12'h00C, 32'h700);
    wr(12'h010, 32'h2);
    acks(2);
    rd(12'h000, 32'h708);
    rd(12'h010, 32'h0);
    rd(12'h00C, 32'h0);
    conclude();
  end
endmodule
